/* design/mmtc_pkg.sv */
// Purpose: Shared constants and types for the multi-mode timer channel.
// Assumes: AXI4-Lite register access with 32-bit data and word-aligned registers.
// Notes: Register indices are word indices; the byte address is four times the index.
package mmtc_pkg;
  // Register indices; byte address is index times four.
  localparam logic [3:0] IDX_MATCH_A = 4'h0;
  localparam logic [3:0] IDX_MATCH_B = 4'h1;
  localparam logic [3:0] IDX_SNAPSHOT = 4'h2;
  localparam logic [3:0] IDX_LOAD = 4'h3;
  localparam logic [3:0] IDX_COUNT = 4'h5;
  localparam logic [3:0] IDX_CTRL = 4'h6;
  localparam logic [3:0] IDX_STATUS = 4'h7;
  localparam int ADDR_LSB = 2;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // Control register field positions.
  localparam int CTL_CM_LSB = 13;
  localparam int CTL_PCS_LSB = 9;
  localparam int CTL_SCS_LSB = 7;
  localparam int CTL_ONCE = 6;
  localparam int CTL_LENGTH = 5;
  localparam int CTL_DIR = 4;
  localparam int CTL_REINIT = 3;
  localparam int CTL_OM_LSB = 0;
  // Status and control register field positions.
  localparam int ST_MATCH = 15;
  localparam int ST_MATCH_IE = 14;
  localparam int ST_ROLL = 13;
  localparam int ST_ROLL_IE = 12;
  localparam int ST_EDGE = 11;
  localparam int ST_EDGE_IE = 10;
  localparam int ST_INV = 9;
  localparam int ST_INPUT = 8;
  localparam int ST_CAP_LSB = 6;
  localparam int ST_BCAST = 5;
  // Count behaviour codes.
  localparam logic [2:0] CM_STOP = 3'h0;
  localparam logic [2:0] CM_EDGE1 = 3'h1;
  localparam logic [2:0] CM_BOTH = 3'h2;
  localparam logic [2:0] CM_GATED = 3'h3;
  localparam logic [2:0] CM_QUAD = 3'h4;
  localparam logic [2:0] CM_SIGNED = 3'h5;
  localparam logic [2:0] CM_TRIG = 3'h6;
  localparam logic [2:0] CM_CASCADE = 3'h7;
  // Output flag behaviour codes.
  localparam logic [2:0] OM_ACTIVE = 3'h0;
  localparam logic [2:0] OM_CLR = 3'h1;
  localparam logic [2:0] OM_SET = 3'h2;
  localparam logic [2:0] OM_TOG = 3'h3;
  localparam logic [2:0] OM_ALT = 3'h4;
  localparam logic [2:0] OM_SET_EDGE = 3'h5;
  localparam logic [2:0] OM_SET_ROLL = 3'h6;
  localparam logic [2:0] OM_GCLK = 3'h7;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_MIN = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {MMTC_IDLE, MMTC_WRESP, MMTC_RRESP} mmtc_bus_e;
endpackage

/* design/mmtc_evt_if.sv */
// Purpose: Carries the per-cycle counting events from the edge front end to the channel.
// Assumes: Single clock domain.
// Notes: All signals are one-cycle pulses except the levels named as such, and prim_rise and tick, which stay high with the undivided clock.
`timescale 1ns/10ps
interface mmtc_evt_if;
  logic prim_rise;
  logic prim_fall;
  logic sec_rise;
  logic sec_fall;
  logic sec_level;
  logic quad_up;
  logic quad_dn;
  logic tick;
  modport src (output prim_rise, prim_fall, sec_rise, sec_fall, sec_level, quad_up, quad_dn,
    output tick);
  modport dst (input prim_rise, prim_fall, sec_rise, sec_fall, sec_level, quad_up, quad_dn,
    input tick);
endinterface

/* design/mmtc_edge.sv */
// Purpose: Source selection, prescaler, inversion and edge detection.
// Assumes: Pins are synchronous to the clock.
// Notes: Edges are registered, so an event shows one cycle after the input change.
`timescale 1ns/10ps
module mmtc_edge (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [3:0] pins_in,
  input wire logic [3:0] flags_in,
  input wire logic [3:0] pcs_in,
  input wire logic [1:0] scs_in,
  input wire logic inv_in,
  input wire logic [1:0] self_idx_in,
  mmtc_evt_if.src evt
);
  typedef struct packed {
    logic [6:0] pre;
    logic prim;
    logic sec;
    logic prim_rise;
    logic prim_fall;
    logic sec_rise;
    logic sec_fall;
    logic quad_up;
    logic quad_dn;
    logic tick;
  } mmtc_edge_s;
  mmtc_edge_s s_q;
  mmtc_edge_s s_d;
  logic prim_raw;
  logic sec_now;
  logic prim_now;
  logic undiv;

  // The prescaler bit chosen gives a square wave; its rising edge counts.
  always_comb
  begin
    undiv = (pcs_in == 4'h8);
    if (pcs_in[3])
    begin
      prim_raw = (pcs_in[2:0] == 3'h0) ? 1'b0 : s_q.pre[pcs_in[2:0] - 3'h1];
    end
    else if (pcs_in[2])
    begin
      prim_raw = (pcs_in[1:0] == self_idx_in) ? 1'b0 : flags_in[pcs_in[1:0]];
    end
    else
    begin
      prim_raw = pins_in[pcs_in[1:0]];
    end
    prim_now = (undiv ? 1'b0 : inv_in) ^ prim_raw;
    sec_now = inv_in ^ pins_in[scs_in];
    s_d = s_q;
    s_d.pre = s_q.pre + 7'h01;
    s_d.prim = prim_now;
    s_d.sec = sec_now;
    s_d.prim_rise = undiv | (prim_now & ~s_q.prim);
    s_d.prim_fall = ~prim_now & s_q.prim;
    s_d.sec_rise = sec_now & ~s_q.sec;
    s_d.sec_fall = ~sec_now & s_q.sec;
    // Quadrature: any change of either phase steps by the phase relation.
    s_d.quad_up = ((prim_now ^ s_q.prim) & (prim_now ^ sec_now))
      | ((sec_now ^ s_q.sec) & ~(prim_now ^ sec_now));
    s_d.quad_dn = ((prim_now ^ s_q.prim) & ~(prim_now ^ sec_now))
      | ((sec_now ^ s_q.sec) & (prim_now ^ sec_now));
    s_d.tick = undiv | (prim_now & ~s_q.prim);
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign evt.prim_rise = s_q.prim_rise;
  assign evt.prim_fall = s_q.prim_fall;
  assign evt.sec_rise = s_q.sec_rise;
  assign evt.sec_fall = s_q.sec_fall;
  assign evt.sec_level = s_q.sec;
  assign evt.quad_up = s_q.quad_up;
  assign evt.quad_dn = s_q.quad_dn;
  assign evt.tick = s_q.tick;
endmodule

/* design/mmtc_channel.sv */
// Purpose: One 16-bit multi-mode counter/timer channel behind an AXI4-Lite slave.
// Assumes: One clock; synchronous active-high reset; other channels' flags arrive on ports.
// Notes: Register indices times four give byte addresses; unmapped accesses get SLVERR.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module mmtc_channel (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [1:0] self_idx_in,
  input wire logic [3:0] count_pin_in,
  input wire logic [3:0] sib_flag_in,
  input wire logic sib_reinit_in,
  output logic out_flag_out,
  output logic bcast_match_out,
  output logic irq_out,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef struct packed {
    logic [15:0] match_a;
    logic [15:0] match_b;
    logic [15:0] snap;
    logic [15:0] load;
    logic [15:0] cnt;
    logic [15:0] ctrl;
    logic [15:0] st;
    logic armed;
    logic use_b;
    logic flag;
    logic bcast;
    logic irq;
    logic aw_got;
    logic w_got;
    logic [3:0] aw_idx;
    logic aw_bad;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [2:0] rdy;
  } mmtc_chan_s;
  mmtc_chan_s s_q;
  mmtc_chan_s s_d;
  mmtc_evt_if evt ();
  localparam int ADDR_LSB_W = mmtc_pkg::ADDR_LSB;

  // Tells whether a byte address is a mapped, word-aligned register.
  function automatic logic mapped(input logic [31:0] a);
    logic [3:0] i;
    i = a[ADDR_LSB_W +: 4];
    mapped = (a[31:6] == 26'h0) && (a[1:0] == 2'h0) && (i != 4'h4) && (i <= mmtc_pkg::IDX_STATUS);
  endfunction

  // Merges a 16-bit write under the two low byte strobes.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
    input logic [1:0] be);
    merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction

  mmtc_edge u_edge (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .pins_in(count_pin_in),
    .flags_in(sib_flag_in),
    .pcs_in(s_q.ctrl[mmtc_pkg::CTL_PCS_LSB +: 4]),
    .scs_in(s_q.ctrl[mmtc_pkg::CTL_SCS_LSB +: 2]),
    .inv_in(s_q.st[mmtc_pkg::ST_INV]),
    .self_idx_in(self_idx_in),
    .evt(evt.src)
  );

  logic [2:0] cm;
  logic [2:0] om;
  logic [1:0] capm;
  logic inv;
  logic step;
  logic down;
  logic hit;
  logic [15:0] target;
  logic roll;
  logic reinit;
  logic sec_edge;
  logic do_cap;
  logic wr_fire;
  logic [15:0] wv;

  // Counting, comparing, flags and output flag for one cycle.
  always_comb
  begin
    s_d = s_q;
    cm = s_q.ctrl[mmtc_pkg::CTL_CM_LSB +: 3];
    om = s_q.ctrl[mmtc_pkg::CTL_OM_LSB +: 3];
    capm = s_q.st[mmtc_pkg::ST_CAP_LSB +: 2];
    inv = s_q.st[mmtc_pkg::ST_INV];
    down = s_q.ctrl[mmtc_pkg::CTL_DIR];
    step = 1'b0;
    sec_edge = evt.sec_rise | evt.sec_fall;
    unique case (cm)
      mmtc_pkg::CM_STOP: step = 1'b0;
      mmtc_pkg::CM_EDGE1: step = evt.prim_rise;
      mmtc_pkg::CM_BOTH: step = evt.prim_rise | evt.prim_fall;
      mmtc_pkg::CM_GATED: step = evt.prim_rise & evt.sec_level;
      mmtc_pkg::CM_QUAD:
      begin
        step = evt.quad_up | evt.quad_dn;
        down = down ^ evt.quad_dn;
      end
      mmtc_pkg::CM_SIGNED:
      begin
        step = evt.prim_rise;
        down = down ^ evt.sec_level;
      end
      mmtc_pkg::CM_TRIG:
      begin
        step = evt.prim_rise & s_q.armed;
        if (sec_edge)
        begin
          s_d.armed = 1'b1;
        end
      end
      mmtc_pkg::CM_CASCADE: step = evt.prim_rise;
    endcase
    // Alternating mode compares against the register whose turn it is.
    if (om == mmtc_pkg::OM_ALT)
    begin
      target = s_q.use_b ? s_q.match_b : s_q.match_a;
    end
    else
    begin
      target = down ? s_q.match_b : s_q.match_a;
    end
    hit = step && (s_q.cnt == target);
    roll = step && (s_q.cnt == (down ? mmtc_pkg::CNT_MIN : mmtc_pkg::CNT_MAX));
    reinit = sib_reinit_in && s_q.ctrl[mmtc_pkg::CTL_REINIT];
    if (reinit || (hit && (s_q.ctrl[mmtc_pkg::CTL_LENGTH] || om == mmtc_pkg::OM_ALT)))
    begin
      s_d.cnt = s_q.load;
    end
    else if (step && !(hit && s_q.ctrl[mmtc_pkg::CTL_ONCE]))
    begin
      s_d.cnt = down ? s_q.cnt - 16'h0001 : s_q.cnt + 16'h0001;
    end
    if (hit)
    begin
      s_d.use_b = ~s_q.use_b;
      s_d.armed = 1'b0;
      if (s_q.ctrl[mmtc_pkg::CTL_ONCE])
      begin
        s_d.ctrl[mmtc_pkg::CTL_CM_LSB +: 3] = mmtc_pkg::CM_STOP;
      end
    end
    // Output flag behaviour.
    unique case (om)
      mmtc_pkg::OM_ACTIVE: s_d.flag = (cm != mmtc_pkg::CM_STOP);
      mmtc_pkg::OM_CLR: s_d.flag = hit ? 1'b0 : s_q.flag;
      mmtc_pkg::OM_SET: s_d.flag = hit ? 1'b1 : s_q.flag;
      mmtc_pkg::OM_TOG: s_d.flag = s_q.flag ^ hit;
      mmtc_pkg::OM_ALT: s_d.flag = s_q.flag ^ hit;
      mmtc_pkg::OM_SET_EDGE: s_d.flag = hit | (s_q.flag & ~sec_edge);
      mmtc_pkg::OM_SET_ROLL: s_d.flag = hit | (s_q.flag & ~roll);
      mmtc_pkg::OM_GCLK:
        s_d.flag = (cm != mmtc_pkg::CM_STOP) & evt.tick & ~s_q.flag;
    endcase
    s_d.bcast = hit & s_q.st[mmtc_pkg::ST_BCAST];
    // Capture selection; inversion already swapped the edge sense.
    unique case (capm)
      2'h0: do_cap = 1'b0;
      2'h1: do_cap = evt.sec_rise;
      2'h2: do_cap = evt.sec_fall;
      2'h3: do_cap = sec_edge;
    endcase
    if (do_cap && cm != mmtc_pkg::CM_STOP)
    begin
      s_d.snap = s_q.cnt;
    end
    // Register writes, then hardware sets win over software clears.
    wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
    wv = merge(16'h0000, s_q.wdata, s_q.wstrb);
    if (wr_fire)
    begin
      s_d.bvalid = 1'b1;
      s_d.bresp = s_q.aw_bad ? mmtc_pkg::RESP_SLVERR : mmtc_pkg::RESP_OKAY;
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      if (!s_q.aw_bad)
      begin
        unique case (s_q.aw_idx)
          mmtc_pkg::IDX_MATCH_A: s_d.match_a = merge(s_q.match_a, s_q.wdata, s_q.wstrb);
          mmtc_pkg::IDX_MATCH_B: s_d.match_b = merge(s_q.match_b, s_q.wdata, s_q.wstrb);
          mmtc_pkg::IDX_SNAPSHOT: s_d.snap = merge(s_q.snap, s_q.wdata, s_q.wstrb);
          mmtc_pkg::IDX_LOAD: s_d.load = merge(s_q.load, s_q.wdata, s_q.wstrb);
          mmtc_pkg::IDX_COUNT: s_d.cnt = merge(s_q.cnt, s_q.wdata, s_q.wstrb);
          mmtc_pkg::IDX_CTRL:
          begin
            s_d.ctrl = merge(s_q.ctrl, s_q.wdata, s_q.wstrb);
            s_d.armed = 1'b0;
            s_d.use_b = 1'b0;
          end
          mmtc_pkg::IDX_STATUS:
          begin
            s_d.st = merge(s_q.st, s_q.wdata, s_q.wstrb);
            // Flags only clear by writing 0; writing 1 keeps the old value.
            s_d.st[mmtc_pkg::ST_MATCH] = s_q.st[mmtc_pkg::ST_MATCH] & (wv[mmtc_pkg::ST_MATCH]
              | ~s_q.wstrb[1]);
            s_d.st[mmtc_pkg::ST_ROLL] = s_q.st[mmtc_pkg::ST_ROLL] & (wv[mmtc_pkg::ST_ROLL]
              | ~s_q.wstrb[1]);
            s_d.st[mmtc_pkg::ST_EDGE] = s_q.st[mmtc_pkg::ST_EDGE] & (wv[mmtc_pkg::ST_EDGE]
              | ~s_q.wstrb[1]);
          end
          default: s_d.st = s_q.st;
        endcase
      end
    end
    if (hit)
    begin
      s_d.st[mmtc_pkg::ST_MATCH] = 1'b1;
    end
    if (roll)
    begin
      s_d.st[mmtc_pkg::ST_ROLL] = 1'b1;
    end
    if (do_cap && cm != mmtc_pkg::CM_STOP)
    begin
      s_d.st[mmtc_pkg::ST_EDGE] = 1'b1;
    end
    s_d.st[mmtc_pkg::ST_INPUT] = evt.sec_level;
    s_d.irq = (s_d.st[mmtc_pkg::ST_MATCH] & s_d.st[mmtc_pkg::ST_MATCH_IE])
      | (s_d.st[mmtc_pkg::ST_ROLL] & s_d.st[mmtc_pkg::ST_ROLL_IE])
      | (s_d.st[mmtc_pkg::ST_EDGE] & s_d.st[mmtc_pkg::ST_EDGE_IE]);
    // Write address and data are taken independently, in either order.
    if (s_axi_awvalid && !s_q.aw_got && !s_q.bvalid)
    begin
      s_d.aw_got = 1'b1;
      s_d.aw_idx = s_axi_awaddr[ADDR_LSB_W +: 4];
      s_d.aw_bad = !mapped(s_axi_awaddr) || (s_axi_awaddr[ADDR_LSB_W +: 4] == 4'h4);
    end
    if (s_axi_wvalid && !s_q.w_got && !s_q.bvalid)
    begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata[15:0];
      s_d.wstrb = s_axi_wstrb[1:0];
    end
    if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end
    // Reads return the current value, zero-extended to 32 bits.
    if (s_axi_arvalid && !s_q.rvalid)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = mapped(s_axi_araddr) ? mmtc_pkg::RESP_OKAY : mmtc_pkg::RESP_SLVERR;
      s_d.rdata = 32'h0000_0000;
      if (mapped(s_axi_araddr))
      begin
        unique case (s_axi_araddr[ADDR_LSB_W +: 4])
          mmtc_pkg::IDX_MATCH_A: s_d.rdata[15:0] = s_q.match_a;
          mmtc_pkg::IDX_MATCH_B: s_d.rdata[15:0] = s_q.match_b;
          mmtc_pkg::IDX_SNAPSHOT: s_d.rdata[15:0] = s_q.snap;
          mmtc_pkg::IDX_LOAD: s_d.rdata[15:0] = s_q.load;
          mmtc_pkg::IDX_COUNT: s_d.rdata[15:0] = s_q.cnt;
          mmtc_pkg::IDX_CTRL: s_d.rdata[15:0] = s_q.ctrl;
          mmtc_pkg::IDX_STATUS: s_d.rdata[15:0] = s_q.st;
          default: s_d.rdata = 32'h0000_0000;
        endcase
      end
    end
    else if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end
    // Readies are registered so that every bus output leaves a flop.
    s_d.rdy = {!s_d.rvalid, !s_d.w_got && !s_d.bvalid, !s_d.aw_got && !s_d.bvalid};
  end

  // Chip reset clears everything except the readies, which it sets; count mode 000 leaves the counter stopped.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      s_q <= '0;
      s_q.rdy <= 3'h7;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign out_flag_out = s_q.flag;
  assign bcast_match_out = s_q.bcast;
  assign irq_out = s_q.irq;
  assign s_axi_awready = s_q.rdy[0];
  assign s_axi_wready = s_q.rdy[1];
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.rdy[2];
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rdata = s_q.rdata;
endmodule

/* tb/mmtc_far_model.sv */
// Purpose: Far-side model: counter input pins and sibling channel flags.
// Assumes: Pins are synchronous levels sampled by the channel clock.
// Notes: Every change lands by non-blocking assignment just after an edge.
`timescale 1ns/10ps
module mmtc_far_model (
  input wire logic ref_clk_in,
  output logic [3:0] pins_out,
  output logic [3:0] flags_out,
  output logic reinit_out
);
  // All lines start quiet so the channel sees no edge at time zero.
  initial
  begin
    pins_out = 4'h0;
    flags_out = 4'h0;
    reinit_out = 1'b0;
  end

  // Level changes on pins and flags; no glitch ever shorter than one cycle.
  task automatic set_pins(input logic [3:0] v);
    @(posedge ref_clk_in);
    pins_out <= v;
  endtask

  task automatic set_pin(input int i, input logic v);
    @(posedge ref_clk_in);
    pins_out[i] <= v;
  endtask

  task automatic set_flag(input int i, input logic v);
    @(posedge ref_clk_in);
    flags_out[i] <= v;
  endtask

  // A sibling compare broadcast is a single-cycle pulse.
  task automatic pulse_reinit();
    @(posedge ref_clk_in);
    reinit_out <= 1'b1;
    @(posedge ref_clk_in);
    reinit_out <= 1'b0;
  endtask
endmodule

/* tb/mmtc_channel_sva.sv */
// Purpose: Port-level assertions on the timer channel.
// Assumes: One clock; synchronous active-high reset.
// Notes: Bound to every channel instance.
`timescale 1ns/10ps
module mmtc_channel_sva (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic out_flag_out,
  input wire logic irq_out,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // Checks are muted in reset, since every register is being forced then.
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  // Idle after reset; answers stand until taken; new requests wait for the answer; answers come promptly; hole reads are refused.
  reset_state_a: assert property (
    $fell(rst_in) |-> !out_flag_out && !irq_out && !s_axi_bvalid && s_axi_arready)
    else $error("channel not idle after reset");
  bvalid_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rvalid_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  write_latency_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##[1:2] s_axi_bvalid)
    else $error("write response late");
  read_latency_a: assert property (
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data late");
  write_refuse_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  read_refuse_a: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during data");
  unmapped_read_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 32'h10 |-> ##[1:2]
    (s_axi_rvalid && s_axi_rresp == mmtc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0))
    else $error("hole read not refused");
endmodule

bind mmtc_channel mmtc_channel_sva i_mmtc_channel_sva (.ref_clk_in(ref_clk_in),
  .rst_in(rst_in), .out_flag_out(out_flag_out), .irq_out(irq_out),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

/* tb/tb.sv */
// Purpose: Self-checking bench for the timer channel.
// Assumes: Pin events reach the counter two edges after the pin moves.
// Notes: Waits after pin moves cover that pipeline; bus waits follow handshakes.
`timescale 1ns/10ps
module tb;
  localparam logic [7:0] A_MA = 8'h00;
  localparam logic [7:0] A_SN = 8'h08;
  localparam logic [7:0] A_LD = 8'h0C;
  localparam logic [7:0] A_CNT = 8'h14;
  localparam logic [7:0] A_CTL = 8'h18;
  localparam logic [7:0] A_ST = 8'h1C;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, out_flag, bcast, irq, reinit;
  logic [1:0] bresp, rresp, last_bresp, last_rresp;
  logic [3:0] pins, flags;
  int mismatches = 0;
  int num_checks = 0;

  // Free-running 100 MHz clock.
  always #5 ref_clk_in = ~ref_clk_in;

  mmtc_far_model i_mmtc_far_model (.ref_clk_in(ref_clk_in), .pins_out(pins),
    .flags_out(flags), .reinit_out(reinit));
  mmtc_channel i_mmtc_channel (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .self_idx_in(2'h0),
    .count_pin_in(pins), .sib_flag_in(flags), .sib_reinit_in(reinit), .out_flag_out(out_flag),
    .bcast_match_out(bcast), .irq_out(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Address and data go out together; each drops once taken, bready is raised with them and held until bvalid.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    awaddr <= {24'h0, a};
    wdata <= {16'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge ref_clk_in);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    last_bresp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_in);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge ref_clk_in);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    last_rresp = rresp;
    rready <= 1'b0;
  endtask

  // Reads a register and compares only the bits under the mask.
  task automatic rdc(input string nm, input logic [7:0] a, input logic [15:0] m,
    input logic [15:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(nm, {16'h0, e}, d & {16'h0, m});
  endtask

  // Stopping first keeps stale pin events out of the new setup.
  task automatic cfg(input logic [15:0] st, input logic [15:0] cnt, input logic [15:0] ctl);
    i_mmtc_far_model.set_pins(4'h0);
    wr(A_CTL, 16'h0000);
    wr(A_ST, st);
    wr(A_CNT, cnt);
    wr(A_CTL, ctl);
  endtask

  task automatic pulse(input int i);
    i_mmtc_far_model.set_pin(i, 1'b1);
    wt(3);
    i_mmtc_far_model.set_pin(i, 1'b0);
    wt(4);
  endtask

  task automatic wait_bc(output int n);
    n = 0;
    do
    begin
      @(posedge ref_clk_in);
      n++;
    end
    while (bcast !== 1'b1 && n < 200);
  endtask

  task automatic t_reset();
    logic [31:0] d;
    for (int i = 0; i < 8; i++)
      if (i != 4)
        rdc("reset value", 8'(i * 4), 16'hFFFF, 16'h0000);
    rd(8'h10, d);
    chk("hole read resp", {30'h0, mmtc_pkg::RESP_SLVERR}, {30'h0, last_rresp});
    wr(8'h10, 16'h1234);
    chk("hole write resp", {30'h0, mmtc_pkg::RESP_SLVERR}, {30'h0, last_bresp});
  endtask

  task automatic t_inv();
    for (int i = 0; i < 2; i++)
    begin
      cfg(i ? 16'h0200 : 16'h0000, 16'h0000, {mmtc_pkg::CM_EDGE1, 13'h0000});
      i_mmtc_far_model.set_pin(0, 1'b1);
      wt(4);
      rdc("count after rise", A_CNT, 16'hFFFF, i ? 16'h0000 : 16'h0001);
      rdc("input level", A_ST, 16'h0100, i ? 16'h0000 : 16'h0100);
      i_mmtc_far_model.set_pin(0, 1'b0);
      wt(4);
      rdc("count after fall", A_CNT, 16'hFFFF, 16'h0001);
    end
  endtask

  task automatic t_modes();
    wr(A_MA, 16'h0100);
    cfg(16'h0000, 16'h0000, 16'h0000);
    pulse(0);
    rdc("stopped count", A_CNT, 16'hFFFF, 16'h0000);
    cfg(16'h0000, 16'h0000, {mmtc_pkg::CM_BOTH, 13'h0000});
    pulse(0);
    rdc("both edges", A_CNT, 16'hFFFF, 16'h0002);
    cfg(16'h0000, 16'h0000, {mmtc_pkg::CM_GATED, 4'h0, 2'h1, 7'h00});
    pulse(0);
    i_mmtc_far_model.set_pin(1, 1'b1);
    pulse(0);
    rdc("gated count", A_CNT, 16'hFFFF, 16'h0001);
    cfg(16'h0000, 16'h0010, {mmtc_pkg::CM_SIGNED, 4'h0, 2'h1, 7'h00});
    pulse(0);
    i_mmtc_far_model.set_pin(1, 1'b1);
    pulse(0);
    pulse(0);
    rdc("signed count", A_CNT, 16'hFFFF, 16'h000F);
    cfg(16'h0000, 16'h0000, {mmtc_pkg::CM_TRIG, 4'h0, 2'h1, 7'h00});
    pulse(0);
    i_mmtc_far_model.set_pin(1, 1'b1);
    pulse(0);
    pulse(0);
    rdc("triggered count", A_CNT, 16'hFFFF, 16'h0002);
  endtask

  // Down count from zero rolls over; the flag is masked, then cleared.
  task automatic t_roll();
    cfg(16'h1000, 16'h0000, {mmtc_pkg::CM_EDGE1, 6'h00, 4'h2, 3'h0});
    pulse(0);
    rdc("down count", A_CNT, 16'hFFFF, 16'hFFFF);
    rdc("rollover flag", A_ST, 16'h2000, 16'h2000);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(A_ST, 16'h2000);
    wt(2);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(A_ST, 16'h0000);
    rdc("rollover cleared", A_ST, 16'h2000, 16'h0000);
  endtask

  task automatic t_once();
    wr(A_MA, 16'h0005);
    cfg(16'h0200, 16'h0000, {mmtc_pkg::CM_EDGE1, 4'h8, 2'h0, 4'h8, 3'h0});
    wt(20);
    rdc("one-shot stop", A_CNT, 16'hFFFF, 16'h0005);
    rdc("mode forced off", A_CTL, 16'hE000, 16'h0000);
    rdc("match flag", A_ST, 16'h8000, 16'h8000);
  endtask

  task automatic t_reload();
    logic f;
    int n;
    wr(A_LD, 16'h0002);
    wr(A_MA, 16'h0004);
    cfg(16'h0020, 16'h0002, {mmtc_pkg::CM_EDGE1, 4'h8, 2'h0, 4'h4, mmtc_pkg::OM_TOG});
    wait_bc(n);
    f = out_flag;
    wait_bc(n);
    chk("reload period", 32'h3, 32'(n));
    chk("flag toggled", {31'h0, ~f}, {31'h0, out_flag});
  endtask

  task automatic t_capture();
    cfg(16'h0040, 16'h1234, {mmtc_pkg::CM_EDGE1, 4'h0, 2'h1, 7'h00});
    i_mmtc_far_model.set_pin(1, 1'b1);
    wt(4);
    rdc("snapshot", A_SN, 16'hFFFF, 16'h1234);
    rdc("edge flag", A_ST, 16'h0800, 16'h0800);
    wr(A_ST, 16'h0040);
    rdc("edge flag cleared", A_ST, 16'h0800, 16'h0000);
  endtask

  task automatic t_sibling();
    wr(A_LD, 16'h0007);
    cfg(16'h0000, 16'h0055, {mmtc_pkg::CM_EDGE1, 6'h00, 4'h1, 3'h0});
    i_mmtc_far_model.pulse_reinit();
    wt(3);
    rdc("reinit load", A_CNT, 16'hFFFF, 16'h0007);
    cfg(16'h0000, 16'h0055, {mmtc_pkg::CM_EDGE1, 13'h0000});
    i_mmtc_far_model.pulse_reinit();
    wt(3);
    rdc("reinit ignored", A_CNT, 16'hFFFF, 16'h0055);
    cfg(16'h0000, 16'h0000, {mmtc_pkg::CM_EDGE1, 4'h4, 9'h000});
    i_mmtc_far_model.set_flag(0, 1'b1);
    wt(4);
    rdc("own flag source", A_CNT, 16'hFFFF, 16'h0000);
    cfg(16'h0000, 16'h0000, {mmtc_pkg::CM_CASCADE, 4'h5, 9'h000});
    i_mmtc_far_model.set_flag(1, 1'b1);
    wt(4);
    rdc("sibling flag source", A_CNT, 16'hFFFF, 16'h0001);
  endtask

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Reset spans three edges, then every scenario runs in turn.
  initial
  begin
    wt(3);
    rst_in <= 1'b0;
    t_reset();
    t_inv();
    t_modes();
    t_roll();
    t_once();
    t_reload();
    t_capture();
    t_sibling();
    report_and_stop();
  end

  // The run needs some hundreds of cycles; a hang is cut off well past that.
  initial
  begin
    wt(30000);
    mismatches++;
    $display("Error watchdog expected finish seen hang");
    report_and_stop();
  end
endmodule
